// ===== core/srg_pkg.sv
// Constants, types and helpers shared by the reference-pulse generator
`default_nettype none
package srg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int COUNT_W = 8;
    localparam int RATE_W = 13;
    localparam int RSEL_W = 4;
    localparam int COINC_W = 7;
    localparam int PHASE_W = 8;
    localparam int MAX_OUT = 16;

    localparam logic [ADDR_W-1:0] ADR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADR_COUNT = 8'h01;
    localparam logic [ADDR_W-1:0] ADR_RATE = 8'h02;
    localparam logic [ADDR_W-1:0] ADR_COINC = 8'h03;
    localparam logic [ADDR_W-1:0] ADR_GDLY = 8'h04;
    localparam logic [ADDR_W-1:0] ADR_STATUS = 8'h05;
    localparam logic [ADDR_W-1:0] ADR_REF_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] ADR_CLK_BASE = 8'h20;

    // Control register bit positions
    localparam int CTRL_MODE = 0;
    localparam int CTRL_SRC = 1;
    localparam int CTRL_IDLE = 2;
    localparam int CTRL_REL = 3;
    localparam int CTRL_W = 3;

    // Status register fields
    localparam int STAT_ARMED = 8;
    localparam int STAT_BUSY = 9;

    localparam logic [CTRL_W-1:0] RST_CTRL = 3'h0;
    localparam logic [COUNT_W-1:0] RST_COUNT = 8'h01;
    localparam logic [RSEL_W-1:0] RST_RATE = 4'h0;
    localparam logic [COINC_W-1:0] RST_COINC = 7'h01;
    localparam logic [PHASE_W-1:0] RST_DELAY = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } srg_state_e;

    // Per-output configuration, laid out as in its register
    typedef struct packed {
        logic [1:0] swing;
        logic       parking;
        logic [2:0] fine;
        logic [2:0] coarse;
    } srg_ref_cfg_s;
    localparam int REF_CFG_W = 9;
    localparam srg_ref_cfg_s RST_REF_CFG = 9'h000;

    // What travels down the global delay line
    typedef struct packed {
        logic on;
        logic pulse;
    } srg_evt_s;

    // Divide ratio for each rate select code; unused codes fall back to 64
    function automatic logic [RATE_W-1:0] rate_ratio(
        input logic [RSEL_W-1:0] sel
    );
        case (sel)
            4'h0:    rate_ratio = 13'h0040;
            4'h1:    rate_ratio = 13'h0060;
            4'h2:    rate_ratio = 13'h0080;
            4'h3:    rate_ratio = 13'h00c0;
            4'h4:    rate_ratio = 13'h0100;
            4'h5:    rate_ratio = 13'h0180;
            4'h6:    rate_ratio = 13'h0200;
            4'h7:    rate_ratio = 13'h0300;
            4'h8:    rate_ratio = 13'h0400;
            4'h9:    rate_ratio = 13'h0800;
            4'ha:    rate_ratio = 13'h1000;
            4'hb:    rate_ratio = 13'h1400;
            default: rate_ratio = 13'h0040;
        endcase
    endfunction : rate_ratio

    // True when addr falls in an n-entry block starting at base
    function automatic logic in_block(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] base,
        input int                n
    );
        in_block = (addr >= base) && (int'(addr - base) < n);
    endfunction : in_block
endpackage : srg_pkg
`default_nettype wire

// ===== core/srg_div.sv
// Free-running modulo counter with synchronous clear and wrap flag
`timescale 1ns/100ps
`default_nettype none
module srg_div #(
    parameter int W = 7
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Control
    input  wire logic         clear,
    input  wire logic [W-1:0] div,
    // Status
    output var  logic [W-1:0] count,
    output var  logic         last
);
    logic [W-1:0] count_next;

    initial begin
        if (W < 2 || W > 16) begin
            $error("srg_div width out of range");
        end
    end

    // A divide value of zero behaves like one
    always_comb begin
        last = (div <= {{(W-1){1'b0}}, 1'b1}) ||
               (count == div - {{(W-1){1'b0}}, 1'b1});
        if (clear || last) begin
            count_next = '0;
        end else begin
            count_next = count + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else begin
            count <= count_next;
        end
    end
endmodule : srg_div
`default_nettype wire

// ===== core/srg_dly.sv
// Tapped delay line for the global reference-pulse delay
`timescale 1ns/100ps
`default_nettype none
module srg_dly #(
    parameter int W     = 2,
    parameter int SEL_W = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Data
    input  wire logic [W-1:0]     din,
    input  wire logic [SEL_W-1:0] sel,
    output var  logic [W-1:0]     dout
);
    localparam int STAGES = (1 << SEL_W) - 1;

    logic [W-1:0] pipe_reg [STAGES];
    logic [W-1:0] pipe_next [STAGES];

    initial begin
        if (W < 1 || SEL_W < 1 || SEL_W > 10) begin
            $error("srg_dly parameters out of range");
        end
    end

    always_comb begin
        pipe_next[0] = din;
        for (int i = 1; i < STAGES; i++) begin
            pipe_next[i] = pipe_reg[i-1];
        end
        if (sel == '0) begin
            dout = din;
        end else begin
            dout = pipe_reg[int'(sel) - 1];
        end
    end

    generate
        for (genvar g = 0; g < STAGES; g++) begin : g_stage
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    pipe_reg[g] <= '0;
                end else begin
                    pipe_reg[g] <= pipe_next[g];
                end
            end
        end
    endgenerate
endmodule : srg_dly
`default_nettype wire

// ===== core/srg_top.sv
// Reference-pulse event generator with register port and output states
`timescale 1ns/100ps
`default_nettype none
module srg_top #(
    parameter int NUM_REF = 8,
    parameter int NUM_CH  = 5
) (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst_b,
    // Register port
    input  wire logic [srg_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [srg_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output var  logic [srg_pkg::DATA_W-1:0]  reg_rdata,
    // Trigger pin
    input  wire logic                        external_trigger_input,
    // Reference-pulse outputs
    output var  logic [NUM_REF-1:0]          ref_p,
    output var  logic [NUM_REF-1:0]          ref_n,
    output var  logic [NUM_REF-1:0]          ref_on,
    output var  logic [NUM_REF-1:0]          ref_bias,
    output var  srg_pkg::srg_ref_cfg_s [NUM_REF-1:0] ref_cfg,
    // Channel clock phase settings
    output var  logic [NUM_CH-1:0][srg_pkg::PHASE_W-1:0] clk_phase,
    // Event status
    output var  logic                        event_busy
);
    localparam int CW = srg_pkg::COUNT_W;
    localparam int RW = srg_pkg::RATE_W;

    initial begin
        if (NUM_REF < 1 || NUM_REF > srg_pkg::MAX_OUT ||
            NUM_CH < 1 || NUM_CH > srg_pkg::MAX_OUT) begin
            $error("srg_top output counts out of range");
        end
    end

    // Configuration registers
    logic [srg_pkg::CTRL_W-1:0]   ctrl_reg, ctrl_next;
    logic [CW-1:0]                count_reg, count_next;
    logic [srg_pkg::RSEL_W-1:0]   rate_reg, rate_next;
    logic [srg_pkg::COINC_W-1:0]  coinc_reg, coinc_next;
    logic [srg_pkg::PHASE_W-1:0]  gdly_reg, gdly_next;
    srg_pkg::srg_ref_cfg_s [NUM_REF-1:0] cfg_reg, cfg_next;
    logic [NUM_CH-1:0][srg_pkg::PHASE_W-1:0] ph_reg, ph_next;
    logic [srg_pkg::DATA_W-1:0]   rdata_reg, rdata_next;

    // Event engine state
    srg_pkg::srg_state_e          state_reg, state_next;
    logic [CW-1:0]                remain_reg, remain_next;
    logic                         armed_reg, armed_next;
    logic                         ext_s1_reg, ext_s2_reg, ext_s3_reg;

    // Output stage
    logic [NUM_REF-1:0]           p_next, n_next, on_next, bias_next;

    logic                         rel_wr, wr_src, ext_rise, start;
    logic                         counted, idle_hi;
    logic [RW-1:0]                ratio, half, rate_cnt;
    logic                         rate_last;
    logic [srg_pkg::COINC_W-1:0]  coinc_cnt;
    logic                         coinc_last;
    logic                         gen_pulse;
    srg_pkg::srg_evt_s            evt_src, evt_dly;

    assign counted = !ctrl_reg[srg_pkg::CTRL_MODE];
    assign idle_hi = ctrl_reg[srg_pkg::CTRL_IDLE];
    assign ratio   = srg_pkg::rate_ratio(rate_reg);
    assign half    = ratio >> 1;
    assign ext_rise = ext_s2_reg && !ext_s3_reg;

    // Register writes
    always_comb begin
        ctrl_next  = ctrl_reg;
        count_next = count_reg;
        rate_next  = rate_reg;
        coinc_next = coinc_reg;
        gdly_next  = gdly_reg;
        cfg_next   = cfg_reg;
        ph_next    = ph_reg;
        rel_wr     = 1'b0;
        wr_src     = reg_wdata[srg_pkg::CTRL_SRC];
        if (reg_wr) begin
            if (reg_addr == srg_pkg::ADR_CTRL) begin
                ctrl_next = reg_wdata[srg_pkg::CTRL_W-1:0];
                rel_wr    = reg_wdata[srg_pkg::CTRL_REL];
            end else if (reg_addr == srg_pkg::ADR_COUNT) begin
                count_next = reg_wdata[CW-1:0];
            end else if (reg_addr == srg_pkg::ADR_RATE) begin
                rate_next = reg_wdata[srg_pkg::RSEL_W-1:0];
            end else if (reg_addr == srg_pkg::ADR_COINC) begin
                coinc_next = reg_wdata[srg_pkg::COINC_W-1:0];
            end else if (reg_addr == srg_pkg::ADR_GDLY) begin
                gdly_next = reg_wdata[srg_pkg::PHASE_W-1:0];
            end else if (srg_pkg::in_block(reg_addr,
                         srg_pkg::ADR_REF_BASE, NUM_REF)) begin
                cfg_next[reg_addr - srg_pkg::ADR_REF_BASE] =
                    reg_wdata[srg_pkg::REF_CFG_W-1:0];
            end else if (srg_pkg::in_block(reg_addr,
                         srg_pkg::ADR_CLK_BASE, NUM_CH)) begin
                ph_next[reg_addr - srg_pkg::ADR_CLK_BASE] =
                    reg_wdata[srg_pkg::PHASE_W-1:0];
            end
        end
    end

    // Register reads, data valid for exactly one cycle
    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            if (reg_addr == srg_pkg::ADR_CTRL) begin
                rdata_next[srg_pkg::CTRL_W-1:0] = ctrl_reg;
            end else if (reg_addr == srg_pkg::ADR_COUNT) begin
                rdata_next[CW-1:0] = count_reg;
            end else if (reg_addr == srg_pkg::ADR_RATE) begin
                rdata_next[srg_pkg::RSEL_W-1:0] = rate_reg;
            end else if (reg_addr == srg_pkg::ADR_COINC) begin
                rdata_next[srg_pkg::COINC_W-1:0] = coinc_reg;
            end else if (reg_addr == srg_pkg::ADR_GDLY) begin
                rdata_next[srg_pkg::PHASE_W-1:0] = gdly_reg;
            end else if (reg_addr == srg_pkg::ADR_STATUS) begin
                rdata_next[CW-1:0] = remain_reg;
                rdata_next[srg_pkg::STAT_ARMED] = armed_reg;
                rdata_next[srg_pkg::STAT_BUSY] = state_reg != srg_pkg::ST_IDLE;
            end else if (srg_pkg::in_block(reg_addr,
                         srg_pkg::ADR_REF_BASE, NUM_REF)) begin
                rdata_next[srg_pkg::REF_CFG_W-1:0] =
                    cfg_reg[reg_addr - srg_pkg::ADR_REF_BASE];
            end else if (srg_pkg::in_block(reg_addr,
                         srg_pkg::ADR_CLK_BASE, NUM_CH)) begin
                rdata_next[srg_pkg::PHASE_W-1:0] =
                    ph_reg[reg_addr - srg_pkg::ADR_CLK_BASE];
            end
        end
    end

    // Coincidence divider runs free; its wrap marks the next aligned edge
    srg_div #(.W(srg_pkg::COINC_W)) u_coinc (
        .clk   (sys_clk),
        .rst_b (rst_b),
        .clear (1'b0),
        .div   (coinc_reg),
        .count (coinc_cnt),
        .last  (coinc_last)
    );

    // Pulse period counter, held at zero outside the running state
    srg_div #(.W(RW)) u_rate (
        .clk   (sys_clk),
        .rst_b (rst_b),
        .clear (state_reg != srg_pkg::ST_RUN),
        .div   (ratio),
        .count (rate_cnt),
        .last  (rate_last)
    );

    // Event sequencer
    always_comb begin
        state_next  = state_reg;
        remain_next = remain_reg;
        armed_next  = armed_reg;
        // Busy engine takes no new trigger
        start = (state_reg == srg_pkg::ST_IDLE) &&
                ((rel_wr && !wr_src) ||
                 (armed_reg && ext_rise));
        if (rel_wr && wr_src) begin
            armed_next = 1'b1;
        end else if (start) begin
            armed_next = 1'b0;
        end
        case (state_reg)
            srg_pkg::ST_IDLE: begin
                if (start) begin
                    state_next = srg_pkg::ST_WAIT;
                    // Count of zero is served as one pulse
                    remain_next = (count_reg == '0) ?
                                  {{(CW-1){1'b0}}, 1'b1} : count_reg;
                end
            end
            srg_pkg::ST_WAIT: begin
                if (coinc_last) begin
                    state_next = srg_pkg::ST_RUN;
                end
            end
            srg_pkg::ST_RUN: begin
                if (rate_last) begin
                    if (counted && remain_reg <= {{(CW-1){1'b0}}, 1'b1}) begin
                        state_next = srg_pkg::ST_IDLE;
                    end else if (coinc_last) begin
                        state_next = srg_pkg::ST_RUN;
                    end else begin
                        state_next = srg_pkg::ST_WAIT;
                    end
                    if (counted) begin
                        remain_next = remain_reg - {{(CW-1){1'b0}}, 1'b1};
                    end
                end
            end
            default: begin
                state_next = srg_pkg::ST_IDLE;
            end
        endcase
    end

    assign gen_pulse = (state_reg == srg_pkg::ST_RUN) && (rate_cnt < half);
    assign evt_src.pulse = gen_pulse;
    assign evt_src.on = state_reg != srg_pkg::ST_IDLE;

    // Global delay applies to both pulse and output-on window
    srg_dly #(.W(2), .SEL_W(srg_pkg::PHASE_W)) u_gdly (
        .clk   (sys_clk),
        .rst_b (rst_b),
        .din   (evt_src),
        .sel   (gdly_reg),
        .dout  (evt_dly)
    );

    // Per-output line state: switching, static low, or crosspoint bias
    generate
        for (genvar r = 0; r < NUM_REF; r++) begin : g_ref
            logic parked, active;
            assign parked = cfg_reg[r].parking && idle_hi;
            assign active = evt_dly.on && !parked;
            assign on_next[r] = active;
            assign p_next[r] = active && evt_dly.pulse;
            assign n_next[r] = active ? !evt_dly.pulse : !idle_hi;
            assign bias_next[r] = !active && idle_hi;
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg   <= srg_pkg::RST_CTRL;
            count_reg  <= srg_pkg::RST_COUNT;
            rate_reg   <= srg_pkg::RST_RATE;
            coinc_reg  <= srg_pkg::RST_COINC;
            gdly_reg   <= srg_pkg::RST_DELAY;
            cfg_reg    <= {NUM_REF{srg_pkg::RST_REF_CFG}};
            ph_reg     <= {NUM_CH{srg_pkg::RST_DELAY}};
            rdata_reg  <= '0;
            state_reg  <= srg_pkg::ST_IDLE;
            remain_reg <= '0;
            armed_reg  <= 1'b0;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
            ref_p      <= '0;
            ref_n      <= '1;
            ref_on     <= '0;
            ref_bias   <= '0;
            event_busy <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            count_reg  <= count_next;
            rate_reg   <= rate_next;
            coinc_reg  <= coinc_next;
            gdly_reg   <= gdly_next;
            cfg_reg    <= cfg_next;
            ph_reg     <= ph_next;
            rdata_reg  <= rdata_next;
            state_reg  <= state_next;
            remain_reg <= remain_next;
            armed_reg  <= armed_next;
            ext_s1_reg <= external_trigger_input;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
            ref_p      <= p_next;
            ref_n      <= n_next;
            ref_on     <= on_next;
            ref_bias   <= bias_next;
            event_busy <= state_next != srg_pkg::ST_IDLE;
        end
    end

    // Settings go to the analog delay cells straight from their registers
    assign reg_rdata = rdata_reg;
    assign ref_cfg   = cfg_reg;
    assign clk_phase = ph_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_last_wrap;
        state_reg == srg_pkg::ST_RUN && rate_last && counted &&
        remain_reg == {{(CW-1){1'b0}}, 1'b1};
    endsequence
    sequence s_go_wait;
        state_reg == srg_pkg::ST_WAIT;
    endsequence

    a_release_loads: assert property (
        (state_reg == srg_pkg::ST_IDLE && rel_wr && !wr_src &&
         count_reg != '0) |=> s_go_wait ##0 remain_reg == $past(count_reg))
        else $error("release did not load count");
    a_ext_start: assert property (
        (state_reg == srg_pkg::ST_IDLE && armed_reg && ext_rise && !rel_wr)
        |=> s_go_wait ##0 !armed_reg)
        else $error("armed trigger edge did not start event");
    a_count_stop: assert property (
        s_last_wrap |=> state_reg == srg_pkg::ST_IDLE ##0 !evt_src.on)
        else $error("counted event did not stop");
    a_busy_ignore: assert property (
        (state_reg == srg_pkg::ST_RUN && ext_rise && !rate_last)
        |=> remain_reg == $past(remain_reg))
        else $error("trigger disturbed running event");
    a_cont_ignore: assert property (
        (state_reg == srg_pkg::ST_RUN && rate_last && !counted)
        |=> state_reg != srg_pkg::ST_IDLE && $stable(remain_reg))
        else $error("continuous run used pulse count");
    a_pulse_align: assert property (
        $rose(gen_pulse) |-> coinc_cnt == '0)
        else $error("pulse started off coincidence");
    a_pulse_width: assert property (
        $fell(gen_pulse) && state_reg == srg_pkg::ST_RUN |-> rate_cnt == half)
        else $error("pulse high time wrong");
    a_idle_level: assert property (
        (!evt_dly.on && !idle_hi) |=> ref_p == '0 && ref_n == '1 &&
                                      ref_bias == '0)
        else $error("idle low level wrong");
    a_idle_cross: assert property (
        (!evt_dly.on && idle_hi) |=> ref_bias == '1 && ref_on == '0)
        else $error("crosspoint idle level wrong");
endmodule : srg_top
`default_nettype wire

// ===== verif/srg_rx_model.sv
// Converter-side model: counts reference pulses, drives the trigger pin
`timescale 1ns/100ps
`default_nettype none
module srg_rx_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Pulse input and trigger request
    input  wire logic        ref_in,
    input  wire logic        fire,
    // Trigger pin and observations
    output logic             trig,
    output var  logic [15:0] pulses,
    output var  logic [15:0] period
);
    logic        last_reg;
    logic [15:0] gap_reg;
    logic [2:0]  hold_reg;
    assign trig = |hold_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {last_reg, gap_reg, hold_reg, pulses, period} <= '0;
        end else begin
            last_reg <= ref_in;
            hold_reg <= fire ? 3'h7 : hold_reg >> 1;
            gap_reg <= (ref_in && !last_reg) ? 16'h0001 : gap_reg + 16'h0001;
            if (ref_in && !last_reg) begin
                pulses <= pulses + 16'h0001;
                period <= gap_reg;
            end
        end
    end
endmodule : srg_rx_model
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the reference-pulse event generator
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        fire = 1'b0;
    logic        trig;
    logic        busy;
    logic [15:0] reg_rdata, pulses, period, base;
    logic [7:0]  ref_p, ref_n, ref_on, ref_bias, n;
    logic [3:0]  sel;
    logic [71:0] cfg_out;
    logic [39:0] phase_out;
    int          failures = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          ratio_tab[12] = '{64, 96, 128, 192, 256, 384, 512, 768,
                                   1024, 2048, 4096, 5120};
    always #12.5 sys_clk = ~sys_clk;
    srg_top DUT (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .external_trigger_input(trig), .ref_p(ref_p),
        .ref_n(ref_n), .ref_on(ref_on), .ref_bias(ref_bias),
        .ref_cfg(cfg_out), .clk_phase(phase_out), .event_busy(busy));
    srg_rx_model rx (.clk(sys_clk), .rst_b(rst_b), .ref_in(ref_p[1]),
        .fire(fire), .trig(trig), .pulses(pulses), .period(period));
    task automatic chk(input string what, input logic [15:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Expected pulse period for a rate select code
    function automatic logic [15:0] exp_period(input logic [3:0] s);
        return (s < 4'hc) ? 16'(ratio_tab[s]) : 16'h0040;
    endfunction : exp_period
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk("reg", exp, reg_rdata);
    endtask : rd
    // Trigger pin start takes several edges, so let busy rise first
    task automatic idle_wait;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        while (busy !== 1'b0) @(negedge sys_clk);
        repeat (3) @(posedge sys_clk);
    endtask : idle_wait
    task automatic complete_run;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 90000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(32'h3e9ec807));
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        chk("idle_n", 16'h00ff, {8'h00, ref_n});
        rd(8'h01, 16'h0001);
        rd(8'h04, 16'h0000);
        rd(8'h20, 16'h0000);
        rd(8'h7f, 16'h0000);
        $display("reset values done");
        wr(8'h03, 16'h0004);
        wr(8'h21, 16'h0010);
        rd(8'h21, 16'h0010);
        chk("phase", 16'h0010, {8'h00, phase_out[15:8]});
        for (int t = 0; t < 3; t++) begin
            n = (t == 0) ? 8'h01 : (t == 1) ? 8'($urandom_range(2, 4)) : 8'hff;
            sel = (t == 1) ? 4'($urandom_range(0, 11)) : 4'h0;
            wr(8'h01, {8'h00, n});
            wr(8'h02, {12'h000, sel});
            base = pulses;
            wr(8'h00, 16'h0008);
            repeat (40) @(posedge sys_clk);
            fire <= 1'b1;
            @(posedge sys_clk);
            fire <= 1'b0;
            wr(8'h00, 16'h0008);
            idle_wait();
            chk("pulses", {8'h00, n}, pulses - base);
            chk("ref_on", 16'h0000, {8'h00, ref_on});
            if (n > 1) chk("period", exp_period(sel), period);
            $display("counted burst of %0d done", n);
        end
        wr(8'h01, 16'h0001);
        base = pulses;
        wr(8'h00, 16'h000a);
        repeat (20) @(posedge sys_clk);
        chk("armed", 16'h0000, {15'h0000, busy});
        rd(8'h05, 16'h0100);
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        idle_wait();
        chk("ext", 16'h0001, pulses - base);
        $display("external trigger done");
        wr(8'h01, 16'h0000);
        base = pulses;
        wr(8'h00, 16'h0009);
        repeat (800) @(posedge sys_clk);
        chk("cont", 16'h0001, {15'h0000, busy && (pulses - base > 16'd8)});
        wr(8'h00, 16'h0000);
        idle_wait();
        chk("cont_off", 16'h0000, {8'h00, ref_on});
        $display("continuous mode done");
        wr(8'h10, 16'h00c0);
        wr(8'h00, 16'h000c);
        repeat (12) @(posedge sys_clk);
        chk("cfg", 16'h00c0, {7'h00, cfg_out[8:0]});
        chk("parked", 16'h00fe, {8'h00, ref_on});
        idle_wait();
        chk("bias", 16'h00ff, {8'h00, ref_bias});
        $display("idle level done");
        complete_run();
    end
endmodule : testbench
`default_nettype wire
